// >>> verilog/ddi_dev.sv
// Converter input front end: dual-bus and interleaved capture, latency line, transfer mapping
//
// Contract
// [RL1] Strap low selects single-bus interleaved mode
// [RL2] Strap high selects independent dual-bus mode
// [RL3] Dual mode: own port, strobe, clock; code gives channel A the B strobe and clock, and channel B the A ones
// [RL4] Strobe rise captures; channel clock transfers word
// [RL5] Source keeps strobe and clock periods equal
// [RL6] Source: clock rise not after strobe rise
// [RL7] Late clock lags strobe by 2 ns
// [RL8] Select high routes to A, low B
// [RL9] B latch holds while select high
// [RL10] Source sends A/B words at double rate
// [RL11] Shared strobe rise captures both words
// [RL12] Next strobe fall hands words onward
// [RL13] Shared clock halved for converter latches
// [RL14] Pair reset fixes halved clock phase
// [RL15] Halved clock held low during reset
// [RL16] Currents: fs*code/1024 and fs*(1023-code)/1024
// [RL17] Gain strap high: A bias sets both
// [RL18] Full scale is reference times 32
// [RL19] Interleaved mode ignores B port entirely
// [RL20] Offset binary, bit 9 is MSB
// [RL21] Output four clock cycles after write
// [RL22] Halved clock starts low after reset release
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ddi_defs.svh"
module ddi_dev
  import ddi_pkg::*;
#(
  parameter int DW = `DDI_DATA_W,
  parameter int LAT = `DDI_LATENCY,
  parameter int RW = `DDI_REF_W
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  ddi_if.dev pins,
  input wire logic [RW-1:0] i_bias_resistor_pin_a,
  input wire logic [RW-1:0] i_bias_resistor_pin_b,
  output logic [RW+4:0] o_positive_current_out_a,
  output logic [RW+4:0] o_complementary_current_out_a,
  output logic [RW+4:0] o_positive_current_out_b,
  output logic [RW+4:0] o_complementary_current_out_b,
  output logic o_halved_latch_clock,
  output logic o_mode_dual
);

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CW = RW + 5;
  localparam int SW = 2 * DW + 8;

  // ----------------------------------------------------------------
  // Scaling
  // ----------------------------------------------------------------
  function automatic logic [CW-1:0] cur_scale(input logic [CW-1:0] fs, input logic [DW-1:0] code);
    logic [CW+DW-1:0] prod;
    prod = {{DW{1'b0}}, fs} * {{CW{1'b0}}, code};
    cur_scale = prod[CW+DW-1:DW];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire logic [SW-1:0] raw_w;
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  logic [3:0] prev_r;
  logic [2*RW-1:0] bias1_r;
  logic [2*RW-1:0] bias2_r;

  assign raw_w = {pins.port_a, pins.port_b,
                  pins.write_strobe_chan_a, pins.write_strobe_chan_b,
                  pins.update_clock_chan_a, pins.update_clock_chan_b,
                  pins.channel_select, pins.pair_align_reset,
                  pins.bus_mode_strap, pins.gain_set_strap};

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
      bias1_r <= '0;
      bias2_r <= '0;
    end else if (i_ce) begin
      sync1_r <= raw_w;
      sync2_r <= sync1_r;
      prev_r <= sync2_r[7:4];
      bias1_r <= {i_bias_resistor_pin_a, i_bias_resistor_pin_b};
      bias2_r <= bias1_r;
    end
  end

  // ----------------------------------------------------------------
  // Decoded pin levels and edges
  // ----------------------------------------------------------------
  wire logic [DW-1:0] port_s [2];
  wire logic [1:0] wr_lvl;
  wire logic [1:0] ck_lvl;
  wire logic [1:0] wr_rise;
  wire logic [1:0] wr_fall;
  wire logic [1:0] ck_rise;
  wire logic sel_s;
  wire logic pair_rst_s;
  wire logic mode_dual_s;
  wire logic gain_s;
  wire logic ilv;

  assign port_s[0] = sync2_r[2*DW+7:DW+8]; // [RL20]
  assign port_s[1] = sync2_r[DW+7:8];
  assign wr_lvl = sync2_r[7:6];
  assign ck_lvl = sync2_r[5:4];
  assign sel_s = sync2_r[3];
  assign pair_rst_s = sync2_r[2];
  assign mode_dual_s = sync2_r[1];
  assign gain_s = sync2_r[0];
  assign ilv = ~mode_dual_s; // [RL1]
  assign wr_rise = wr_lvl & ~prev_r[3:2];
  assign wr_fall = ~wr_lvl & prev_r[3:2];
  assign ck_rise = ck_lvl & ~prev_r[1:0];

  // ----------------------------------------------------------------
  // Halved converter clock
  // ----------------------------------------------------------------
  logic half_r;
  logic half_nxt;
  logic mode_r;
  wire logic half_rise;

  assign half_rise = ilv & ~pair_rst_s & ck_rise[0] & ~half_r; // [RL13]

  always_comb begin
    half_nxt = half_r;
    if (!ilv || pair_rst_s) begin
      half_nxt = 1'b0; // [RL15]
    end else if (ck_rise[0]) begin
      half_nxt = ~half_r; // [RL14] [RL22]
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      half_r <= 1'b0;
      mode_r <= 1'b0;
    end else if (i_ce) begin
      half_r <= half_nxt;
      mode_r <= mode_dual_s;
    end
  end

  assign o_halved_latch_clock = half_r;
  assign o_mode_dual = mode_r;

  // ----------------------------------------------------------------
  // Per-channel capture, transfer and latency line
  // ----------------------------------------------------------------
  logic [DW-1:0] in_r [2];
  logic [DW-1:0] hand_r [2];
  logic [CW-1:0] pos_r [2];
  logic [CW-1:0] comp_r [2];

  generate
    for (genvar c = 0; c < 2; c++) begin : g_chan
      wire logic [DW-1:0] in_nxt;
      wire logic [DW-1:0] src;
      wire logic step;
      wire logic take_ilv;
      wire logic [RW-1:0] ref_sel;
      wire logic [CW-1:0] fs;
      wire logic [DW-1:0] out_code;
      logic [DW-1:0] pipe_r [LAT-1];

      // A takes the shared port on select high, B on select low
      assign take_ilv = wr_rise[0] & (c == 0 ? sel_s : ~sel_s); // [RL8] [RL11] [RL19]
      assign in_nxt = mode_dual_s ? (wr_rise[c] ? port_s[c] : in_r[c]) // [RL2] [RL3] [RL4]
                                  : (take_ilv ? port_s[0] : in_r[c]); // [RL9]
      assign step = mode_dual_s ? ck_rise[c] : half_rise; // [RL4] [RL13]
      assign src = mode_dual_s ? in_r[c] : hand_r[c];
      assign ref_sel = (gain_s || c == 0) ? bias2_r[2*RW-1:RW] : bias2_r[RW-1:0]; // [RL17]
      assign fs = {{5{1'b0}}, ref_sel} << `DDI_FS_SHIFT; // [RL18]
      assign out_code = pipe_r[LAT-2];

      always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          in_r[c] <= '0;
          hand_r[c] <= '0;
        end else if (i_ce) begin
          in_r[c] <= in_nxt;
          if (ilv && wr_fall[0]) begin
            hand_r[c] <= in_r[c]; // [RL12]
          end
        end
      end

      always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          for (int k = 0; k < LAT - 1; k++) begin
            pipe_r[k] <= '0;
          end
          pos_r[c] <= '0;
          comp_r[c] <= '0;
        end else if (i_ce && step) begin
          pipe_r[0] <= src; // [RL21]
          for (int k = 1; k < LAT - 1; k++) begin
            pipe_r[k] <= pipe_r[k-1];
          end
          pos_r[c] <= cur_scale(fs, out_code); // [RL16]
          comp_r[c] <= cur_scale(fs, `DDI_CODE_MAX - out_code); // [RL16]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output currents
  // ----------------------------------------------------------------
  assign o_positive_current_out_a = pos_r[0];
  assign o_complementary_current_out_a = comp_r[0];
  assign o_positive_current_out_b = pos_r[1];
  assign o_complementary_current_out_b = comp_r[1];

endmodule
`default_nettype wire

// >>> common/ddi_defs.svh
// Constants shared by both ends of the converter input link
`ifndef DDI_DEFS_SVH
`define DDI_DEFS_SVH
`define DDI_DATA_W 10
`define DDI_CODE_MAX 10'h3FF
`define DDI_CODE_SHIFT 10
`define DDI_LATENCY 4
`define DDI_FS_SHIFT 5
`define DDI_REF_W 8
`define DDI_CLK_PERIOD_PS 4000
`define DDI_CLK_LAG_MIN_PS 2000
`define DDI_CLK_LAG_CYC ((`DDI_CLK_LAG_MIN_PS + `DDI_CLK_PERIOD_PS - 1) / `DDI_CLK_PERIOD_PS)
`define DDI_HALF_PERIOD 2
`define DDI_ADDR_CTRL 8'h00
`define DDI_ADDR_DATA_A 8'h04
`define DDI_ADDR_DATA_B 8'h08
`define DDI_ADDR_STATUS 8'h0C
`define DDI_CTRL_EN 0
`define DDI_CTRL_DUAL 1
`define DDI_CTRL_GAIN 2
`define DDI_CTRL_PAIR_RST 3
`define DDI_CTRL_RST 4'h8
`endif

// >>> common/ddi_pkg.sv
// Types shared by both ends of the converter input link
`default_nettype none
package ddi_pkg;
  typedef enum logic [2:0] {
    DDI_ST_IDLE = 3'h1,
    DDI_ST_HIGH = 3'h2,
    DDI_ST_LOW = 3'h4
  } ddi_state_type;
endpackage
`default_nettype wire

// >>> common/ddi_if.sv
// Pin bundle between sample source and converter front end
`timescale 1ns/1ps
`default_nettype none
`include "ddi_defs.svh"
interface ddi_if;
  logic [`DDI_DATA_W-1:0] port_a;
  logic [`DDI_DATA_W-1:0] port_b;
  logic write_strobe_chan_a;
  logic write_strobe_chan_b;
  logic update_clock_chan_a;
  logic update_clock_chan_b;
  logic channel_select;
  logic pair_align_reset;
  logic bus_mode_strap;
  logic gain_set_strap;
  modport dev (
    input port_a, port_b, write_strobe_chan_a, write_strobe_chan_b,
    input update_clock_chan_a, update_clock_chan_b, channel_select,
    input pair_align_reset, bus_mode_strap, gain_set_strap
  );
  modport host (
    output port_a, port_b, write_strobe_chan_a, write_strobe_chan_b,
    output update_clock_chan_a, update_clock_chan_b, channel_select,
    output pair_align_reset, bus_mode_strap, gain_set_strap
  );
endinterface
`default_nettype wire

// >>> verilog/ddi_host.sv
// Sample source: APB registers and strobe, clock and data pin driver
`timescale 1ns/1ps
`default_nettype none
`include "ddi_defs.svh"
module ddi_host
  import ddi_pkg::*;
#(
  parameter int DW = `DDI_DATA_W,
  parameter int HALF = `DDI_HALF_PERIOD
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  ddi_if.host pins
);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [3:0] ctrl_r;
  logic [DW-1:0] data_a_r;
  logic [DW-1:0] data_b_r;
  logic [15:0] words_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic strobe_r;
  logic sel_r;
  wire logic access;
  wire logic wr_en;
  wire logic hit_ctrl;
  wire logic hit_a;
  wire logic hit_b;
  wire logic hit_st;
  wire logic mapped;
  wire logic [31:0] rd_mux;

  assign access = i_psel & i_penable & ~pready_r;
  assign wr_en = i_psel & i_penable & pready_r & i_pwrite;
  assign hit_ctrl = i_paddr == `DDI_ADDR_CTRL;
  assign hit_a = i_paddr == `DDI_ADDR_DATA_A;
  assign hit_b = i_paddr == `DDI_ADDR_DATA_B;
  assign hit_st = i_paddr == `DDI_ADDR_STATUS;
  assign mapped = hit_ctrl | hit_a | hit_b | hit_st;
  assign rd_mux = hit_ctrl ? {28'h0, ctrl_r}
                : hit_a ? {22'h0, data_a_r}
                : hit_b ? {22'h0, data_b_r}
                : hit_st ? {words_r, 14'h0, sel_r, strobe_r}
                : 32'h0;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else if (i_ce) begin
      pready_r <= access;
      pslverr_r <= access & ~mapped;
      prdata_r <= (access && !i_pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= `DDI_CTRL_RST;
      data_a_r <= '0;
      data_b_r <= '0;
    end else if (i_ce && wr_en) begin
      if (hit_ctrl) ctrl_r <= i_pwdata[3:0];
      if (hit_a) data_a_r <= i_pwdata[DW-1:0];
      if (hit_b) data_b_r <= i_pwdata[DW-1:0];
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // Strobe generator
  // ----------------------------------------------------------------
  ddi_state_type state_r;
  ddi_state_type state_nxt;
  logic [7:0] cnt_r;
  logic [DW-1:0] port_a_r;
  logic [DW-1:0] port_b_r;
  wire logic en;
  wire logic dual;
  wire logic tick;
  wire logic present;
  wire logic sel_nxt;

  assign en = ctrl_r[`DDI_CTRL_EN];
  assign dual = ctrl_r[`DDI_CTRL_DUAL];
  assign tick = cnt_r == 8'(HALF - 1);
  assign present = (state_r == DDI_ST_IDLE && en) || (state_r == DDI_ST_HIGH && tick);
  assign sel_nxt = dual ? 1'b0 : ~sel_r; // [RL10]

  always_comb begin
    case (state_r)
      DDI_ST_IDLE: state_nxt = en ? DDI_ST_LOW : DDI_ST_IDLE;
      DDI_ST_LOW: state_nxt = !en ? DDI_ST_IDLE : (tick ? DDI_ST_HIGH : DDI_ST_LOW);
      DDI_ST_HIGH: state_nxt = tick ? (en ? DDI_ST_LOW : DDI_ST_IDLE) : DDI_ST_HIGH;
      default: state_nxt = DDI_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= DDI_ST_IDLE;
      cnt_r <= 8'h00;
      strobe_r <= 1'b0;
      sel_r <= 1'b0;
      port_a_r <= '0;
      port_b_r <= '0;
      words_r <= 16'h0;
    end else if (i_ce) begin
      state_r <= state_nxt;
      cnt_r <= (state_r != state_nxt) ? 8'h00 : cnt_r + 8'h01;
      strobe_r <= state_nxt == DDI_ST_HIGH; // [RL5] [RL6] [RL7]
      if (present) begin
        sel_r <= sel_nxt;
        port_a_r <= (dual || sel_nxt) ? data_a_r : data_b_r;
        port_b_r <= dual ? data_b_r : '0;
      end
      if (state_r == DDI_ST_LOW && state_nxt == DDI_ST_HIGH) begin
        words_r <= words_r + 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign pins.port_a = port_a_r;
  assign pins.port_b = port_b_r;
  assign pins.write_strobe_chan_a = strobe_r;
  assign pins.write_strobe_chan_b = strobe_r;
  assign pins.update_clock_chan_a = strobe_r;
  assign pins.update_clock_chan_b = strobe_r;
  assign pins.channel_select = sel_r;
  assign pins.pair_align_reset = ctrl_r[`DDI_CTRL_PAIR_RST];
  assign pins.bus_mode_strap = dual;
  assign pins.gain_set_strap = ctrl_r[`DDI_CTRL_GAIN];

endmodule
`default_nettype wire

// >>> testbench/ddi_link_properties.sv
// Timing checks on the source-to-converter pin link
`timescale 1ns/1ps
`default_nettype none
`include "ddi_defs.svh"
module ddi_link_properties (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [`DDI_DATA_W-1:0] port_a,
  input wire logic [`DDI_DATA_W-1:0] port_b,
  input wire logic write_strobe_chan_a,
  input wire logic write_strobe_chan_b,
  input wire logic update_clock_chan_a,
  input wire logic update_clock_chan_b,
  input wire logic channel_select,
  input wire logic pair_align_reset,
  input wire logic bus_mode_strap,
  input wire logic o_halved_latch_clock
);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence s_pair_held;
    pair_align_reset [*4];
  endsequence
  sequence s_inter_quiet;
    (!bus_mode_strap && !pair_align_reset) [*4];
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_clock_tied_a: assert property (update_clock_chan_a == write_strobe_chan_a)
    else $error("Channel A clock and strobe differ");
  a_clock_tied_b: assert property (update_clock_chan_b == write_strobe_chan_b)
    else $error("Channel B clock and strobe differ");
  a_strobe_high_span: assert property ($rose(write_strobe_chan_a) |=> write_strobe_chan_a ##1 !write_strobe_chan_a)
    else $error("Strobe high phase length wrong");
  a_strobe_low_span: assert property ($fell(write_strobe_chan_a) |=> !write_strobe_chan_a ##1 write_strobe_chan_a)
    else $error("Strobe low phase length wrong");
  a_data_setup: assert property ($changed(port_a) |-> !write_strobe_chan_a)
    else $error("Word changed while strobe high");
  a_select_alt: assert property (!bus_mode_strap && $changed(channel_select) |=> $stable(channel_select) [*3])
    else $error("Select toggled faster than one word");
  a_port_b_idle: assert property ((!bus_mode_strap) [*8] |-> port_b == 10'h000)
    else $error("B bus active in interleaved mode");
  a_halved_low: assert property (s_pair_held |-> !o_halved_latch_clock)
    else $error("Halved clock high during pair reset");
  a_halved_start: assert property ($fell(pair_align_reset) && !bus_mode_strap |->
    !o_halved_latch_clock ##1 !o_halved_latch_clock ##[1:12] o_halved_latch_clock)
    else $error("Halved clock start after pair reset wrong");
  a_halved_rate: assert property (s_inter_quiet ##0 $changed(o_halved_latch_clock) |=>
    $stable(o_halved_latch_clock) [*3])
    else $error("Halved clock not half the strobe rate");
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Bench driving the source over APB and checking converter outputs
`timescale 1ns/1ps
`default_nettype none
`include "ddi_defs.svh"
module tb
  import ddi_pkg::*;
;
  logic i_core_clk, i_rstn, psel, penable, pwrite, pready, pslverr, halved, dual, slverr, prev;
  logic [7:0] paddr, bias_a, bias_b;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] pos_a, comp_a, pos_b, comp_b, old;
  logic [9:0] codes [3] = '{10'h000, 10'h3FF, 10'h2C5};
  int num_errors, n_checks, rises, n;
  ddi_if link ();
  ddi_host ddi_host_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .pins(link.host));
  ddi_dev ddi_dev_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(1'b1), .pins(link.dev),
    .i_bias_resistor_pin_a(bias_a), .i_bias_resistor_pin_b(bias_b), .o_positive_current_out_a(pos_a),
    .o_complementary_current_out_a(comp_a), .o_positive_current_out_b(pos_b),
    .o_complementary_current_out_b(comp_b), .o_halved_latch_clock(halved), .o_mode_dual(dual));
  ddi_link_properties ddi_link_properties_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .port_a(link.port_a), .port_b(link.port_b), .write_strobe_chan_a(link.write_strobe_chan_a),
    .write_strobe_chan_b(link.write_strobe_chan_b), .update_clock_chan_a(link.update_clock_chan_a),
    .update_clock_chan_b(link.update_clock_chan_b), .channel_select(link.channel_select),
    .pair_align_reset(link.pair_align_reset), .bus_mode_strap(link.bus_mode_strap),
    .o_halved_latch_clock(halved));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    slverr = pslverr;
    if (n >= 50) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [12:0] cur(input logic [7:0] r, input logic [9:0] c, input logic cmp);
    logic [31:0] fs;
    fs = {19'h0, r, 5'h00};
    return 13'((fs * (cmp ? 32'h3FF - {22'h0, c} : {22'h0, c})) >> 10);
  endfunction
  task automatic wait_out(input logic [7:0] ra, input logic [7:0] rb, input logic [9:0] ca, input logic [9:0] cb);
    n = 0;
    while (n < 300 && {pos_a, comp_a, pos_b, comp_b} !==
      {cur(ra, ca, 1'b0), cur(ra, ca, 1'b1), cur(rb, cb, 1'b0), cur(rb, cb, 1'b1)}) begin
      @(posedge i_core_clk);
      n++;
    end
    check("pos_a", 32'(pos_a), 32'(cur(ra, ca, 1'b0)));
    check("comp_a", 32'(comp_a), 32'(cur(ra, ca, 1'b1)));
    check("pos_b", 32'(pos_b), 32'(cur(rb, cb, 1'b0)));
    check("comp_b", 32'(comp_b), 32'(cur(rb, cb, 1'b1)));
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  initial begin
    #160000;
    num_errors++;
    $display("Watchdog expired");
    finish_test();
  end
  initial begin
    {i_rstn, psel, penable, pwrite, paddr, pwdata, num_errors, n_checks} = '0;
    bias_a = 8'h40;
    bias_b = 8'h21;
    repeat (4) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    apb(1'b0, `DDI_ADDR_CTRL, 32'h0);
    check("ctrl_reset", rd, 32'(`DDI_CTRL_RST));
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped_data", rd, 32'h0);
    check("unmapped_err", 32'(slverr), 32'h1);
    $display("Test registers done");
    apb(1'b1, `DDI_ADDR_CTRL, 32'h3);
    foreach (codes[i]) begin
      apb(1'b1, `DDI_ADDR_DATA_A, {22'h0, codes[i]});
      apb(1'b1, `DDI_ADDR_DATA_B, {22'h0, ~codes[i]});
      wait_out(8'h40, 8'h21, codes[i], ~codes[i]);
    end
    check("mode_dual", 32'(dual), 32'h1);
    bias_a <= 8'hFF;
    apb(1'b1, `DDI_ADDR_CTRL, 32'h7);
    wait_out(8'hFF, 8'hFF, codes[2], ~codes[2]);
    $display("Test dual bus done");
    old = pos_a;
    apb(1'b1, `DDI_ADDR_DATA_A, 32'h100);
    n = 0;
    while (link.port_a !== 10'h100 && n < 100) begin
      @(posedge i_core_clk);
      n++;
    end
    rises = 0;
    prev = link.write_strobe_chan_a;
    while (pos_a === old && n < 200) begin
      @(posedge i_core_clk);
      n++;
      if (link.write_strobe_chan_a === 1'b1 && prev === 1'b0) rises++;
      prev = link.write_strobe_chan_a;
    end
    check("latency", 32'(rises), 32'(`DDI_LATENCY + 1));
    $display("Test latency done");
    apb(1'b1, `DDI_ADDR_CTRL, 32'h9);
    apb(1'b1, `DDI_ADDR_DATA_A, 32'h155);
    apb(1'b1, `DDI_ADDR_DATA_B, 32'h2AA);
    check("mode_inter", 32'(dual), 32'h0);
    apb(1'b1, `DDI_ADDR_CTRL, 32'h1);
    wait_out(8'hFF, 8'h21, 10'h155, 10'h2AA);
    $display("Test interleaved done");
    finish_test();
  end
endmodule
`default_nettype wire
